// File: core/pdm_pkg.sv
/*
 Package for the process data port mapper: sizes, mode codes and
 cycle constants. Assumes a 40 MHz clock.
*/
package pdm_pkg;
    localparam int NUM_PORTS = 4;
    localparam int IMG_BYTES = 32;
    localparam int LEN_W = 6;
    localparam int IDX_W = 5;
    localparam int CLK_MHZ = 40;
    localparam int US_PER_SEC = 1000000;
    localparam int TIMEOUT_SEC_DEFAULT = 1;
    localparam logic [LEN_W-1:0] DIO_BYTES = 6'h01;
    localparam logic [LEN_W-1:0] DIO_BYTE_POS = 6'h00;
    localparam int CLASS_A_FIRST = 2;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        PDM_SW_LINK,
        PDM_SW_DOUT,
        PDM_SW_DIN,
        PDM_SW_OFF
    } pdm_sw_mode_t;

    typedef enum logic [1:0] {
        PDM_VAL_NONE,
        PDM_VAL_TYPE_CHECK_REV10,
        PDM_VAL_REV11_BACKUP,
        PDM_VAL_TYPE_CHECK_REV11_RESTORE
    } pdm_policy_t;

    typedef enum logic [1:0] {
        PDM_PS_WAIT,
        PDM_PS_UP,
        PDM_PS_FAIL
    } pdm_port_state_t;
endpackage : pdm_pkg

// File: core/pdm_img_if.sv
/*
 Interface carrying the shared timing ticks between the mapper and its
 cycle timer. Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface pdm_img_if;
    import pdm_pkg::*;
    logic [15:0] cycle_us;
    logic cycle_tick;
    logic us_tick;
    modport timer (input cycle_us, output cycle_tick, output us_tick);
    modport user (output cycle_us, input cycle_tick, input us_tick);
endinterface : pdm_img_if

// File: core/pdm_cycle_timer.sv
/*
 Cycle timer: makes a microsecond tick and a wired link cycle tick.
 Assumes a 40 MHz clock and a cycle time of at least one microsecond.
*/
`timescale 1ns/1ps
module pdm_cycle_timer
    import pdm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    pdm_img_if.timer tif
);
    localparam logic [5:0] US_CYCLES = 6'(CLK_MHZ);

    typedef struct packed {
        logic [5:0] pre;
        logic [15:0] us_cnt;
        logic cyc;
        logic us;
    } pdm_tmr_t;

    pdm_tmr_t st_r;
    pdm_tmr_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.us = 1'b0;
        st_nxt.cyc = 1'b0;
        if (st_r.pre == US_CYCLES - 6'h01)
        begin
            st_nxt.pre = 6'h00;
            st_nxt.us = 1'b1;
            if (st_r.us_cnt + 16'h0001 >= tif.cycle_us)
            begin
                st_nxt.us_cnt = 16'h0000;
                st_nxt.cyc = 1'b1;
            end
            else
            begin
                st_nxt.us_cnt = st_r.us_cnt + 16'h0001;
            end
        end
        else
        begin
            st_nxt.pre = st_r.pre + 6'h01;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign tif.cycle_tick = st_r.cyc;
    assign tif.us_tick = st_r.us;
endmodule : pdm_cycle_timer

// File: core/pdm_port_mapper.sv
/*
 Process data port mapper top: builds the inbound image from four
 wired ports and the digital channels, and splits the outbound image.
 Assumes operational flags and pin levels come from pins of other domains,
 and the configuration is held static by the parameter loader.
*/
`timescale 1ns/1ps
module pdm_port_mapper
    import pdm_pkg::*;
#(
    parameter int TIMEOUT_US_DEFAULT = TIMEOUT_SEC_DEFAULT * US_PER_SEC
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [NUM_PORTS*2-1:0] switching_pin_mode,
    input wire logic [NUM_PORTS-1:0] auxiliary_pin_en,
    input wire logic [NUM_PORTS*LEN_W-1:0] in_len,
    input wire logic [NUM_PORTS*IDX_W-1:0] in_ofs,
    input wire logic [NUM_PORTS*LEN_W-1:0] out_len,
    input wire logic [NUM_PORTS*IDX_W-1:0] out_ofs,
    input wire logic [LEN_W-1:0] agg_in_len,
    input wire logic [LEN_W-1:0] agg_out_len,
    input wire logic [NUM_PORTS-1:0] sw_init_high,
    input wire logic [NUM_PORTS-1:0] aux_init_high,
    input wire logic [15:0] cycle_time_us,
    input wire logic [31:0] timeout_us,
    input wire logic [NUM_PORTS*2-1:0] policy,
    input wire logic [NUM_PORTS*16-1:0] cfg_device_id,
    input wire logic [NUM_PORTS*16-1:0] cfg_vendor_id,
    input wire logic [NUM_PORTS*16-1:0] seen_device_id,
    input wire logic [NUM_PORTS*16-1:0] seen_vendor_id,
    input wire logic [NUM_PORTS-1:0] port_mandatory,
    input wire logic [NUM_PORTS-1:0] port_operational,
    input wire logic [NUM_PORTS-1:0] switching_pin_in,
    input wire logic [NUM_PORTS-1:0] auxiliary_pin_in,
    input wire logic [NUM_PORTS*IMG_BYTES*8-1:0] port_inbound,
    input wire logic [IMG_BYTES*8-1:0] outbound_image,
    output logic [IMG_BYTES*8-1:0] inbound_image,
    output logic [NUM_PORTS*IMG_BYTES*8-1:0] port_outbound,
    output logic [NUM_PORTS-1:0] switching_pin_out,
    output logic [NUM_PORTS-1:0] switching_pin_oe,
    output logic [NUM_PORTS-1:0] auxiliary_pin_out,
    output logic [NUM_PORTS-1:0] auxiliary_pin_oe,
    output logic [NUM_PORTS-1:0] port_failed,
    output logic [NUM_PORTS-1:0] id_mismatch,
    output logic cycle_strobe,
    output logic length_error,
    output logic safe_mode
);
    localparam int W = IMG_BYTES * 8;

    typedef struct packed {
        logic [NUM_PORTS-1:0] sw_s1;
        logic [NUM_PORTS-1:0] sw_s2;
        logic [NUM_PORTS-1:0] aux_s1;
        logic [NUM_PORTS-1:0] aux_s2;
        logic [NUM_PORTS-1:0] op_s1;
        logic [NUM_PORTS-1:0] op_s2;
        logic [NUM_PORTS-1:0] sw_o;
        logic [NUM_PORTS-1:0] aux_o;
        logic [NUM_PORTS-1:0] started;
        logic [NUM_PORTS*32-1:0] wait_us;
        logic [NUM_PORTS*2-1:0] pst;
        logic [NUM_PORTS-1:0] mism;
        logic [W-1:0] in_img;
        logic [NUM_PORTS*W-1:0] out_img;
        logic len_err;
        logic safe;
    } pdm_state_t;

    pdm_state_t st_r;
    pdm_state_t st_nxt;
    pdm_img_if tif ();

    assign tif.cycle_us = cycle_time_us;

    pdm_cycle_timer u_timer (
        .clk(clk),
        .reset(reset),
        .tif(tif)
    );

    function automatic logic is_link(input logic [1:0] m);
        return pdm_sw_mode_t'(m) == PDM_SW_LINK;
    endfunction : is_link

    // Byte i of the destination takes byte (i - ofs) of the source window.
    function automatic logic [W-1:0] place(input logic [W-1:0] src,
        input logic [IDX_W-1:0] ofs, input logic [LEN_W-1:0] len, input logic [W-1:0] dst);
        logic [W-1:0] r;
        logic [LEN_W:0] rel;
        r = dst;
        for (int i = 0; i < IMG_BYTES; i++)
        begin
            rel = (LEN_W+1)'(i) - (LEN_W+1)'(ofs);
            if ((LEN_W+1)'(i) >= (LEN_W+1)'(ofs) && rel < (LEN_W+1)'(len))
            begin
                r[i*8 +: 8] = src[rel[IDX_W-1:0]*8 +: 8];
            end
        end
        return r;
    endfunction : place

    always_comb
    begin
        logic [LEN_W+2:0] sum_in;
        logic [LEN_W+2:0] sum_out;
        logic [W-1:0] img;
        logic [7:0] dio;
        logic miss;
        logic [NUM_PORTS*W-1:0] oimg;
        logic [31:0] limit;
        sum_in = (LEN_W+3)'(DIO_BYTES);
        sum_out = (LEN_W+3)'(DIO_BYTES);
        img = '0;
        dio = RESET_BYTE;
        miss = 1'b0;
        oimg = '0;
        // A zero timeout selects the one second default.
        limit = (timeout_us == 32'h0) ? 32'(TIMEOUT_US_DEFAULT) : timeout_us;
        st_nxt = st_r;
        st_nxt.sw_s1 = switching_pin_in;
        st_nxt.sw_s2 = st_r.sw_s1;
        st_nxt.aux_s1 = auxiliary_pin_in;
        st_nxt.aux_s2 = st_r.aux_s1;
        st_nxt.op_s1 = port_operational;
        st_nxt.op_s2 = st_r.op_s1;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            case (pdm_sw_mode_t'(switching_pin_mode[p*2 +: 2]))
                PDM_SW_DIN: dio[p] = st_r.sw_s2[p];
                PDM_SW_DOUT: dio[p] = st_r.sw_o[p];
                default: dio[p] = 1'b0;
            endcase
            if (p >= CLASS_A_FIRST)
            begin
                dio[p+NUM_PORTS] = auxiliary_pin_en[p] & st_r.aux_s2[p];
            end
            if (is_link(switching_pin_mode[p*2 +: 2]))
            begin
                sum_in = sum_in + (LEN_W+3)'(in_len[p*LEN_W +: LEN_W]);
                sum_out = sum_out + (LEN_W+3)'(out_len[p*LEN_W +: LEN_W]);
                // Place inbound window, shifted past the channel byte.
                img = place(port_inbound[p*W +: W],
                    IDX_W'(in_ofs[p*IDX_W +: IDX_W] + 5'h01), in_len[p*LEN_W +: LEN_W], img);
                oimg[p*W +: W] = place(outbound_image >> 8 >> (out_ofs[p*IDX_W +: IDX_W] * 8),
                    5'h00, out_len[p*LEN_W +: LEN_W], '0);
                case (pdm_port_state_t'(st_r.pst[p*2 +: 2]))
                    PDM_PS_WAIT:
                    begin
                        if (st_r.op_s2[p])
                        begin
                            st_nxt.pst[p*2 +: 2] = 2'(PDM_PS_UP);
                        end
                        else if (st_r.wait_us[p*32 +: 32] >= limit)
                        begin
                            st_nxt.pst[p*2 +: 2] = 2'(PDM_PS_FAIL);
                        end
                        else if (tif.us_tick)
                        begin
                            st_nxt.wait_us[p*32 +: 32] = st_r.wait_us[p*32 +: 32] + 32'h1;
                        end
                    end
                    PDM_PS_UP:
                    begin
                        if (!st_r.op_s2[p])
                        begin
                            st_nxt.pst[p*2 +: 2] = 2'(PDM_PS_WAIT);
                            st_nxt.wait_us[p*32 +: 32] = 32'h0;
                        end
                    end
                    PDM_PS_FAIL:
                    begin
                        if (st_r.op_s2[p])
                        begin
                            st_nxt.pst[p*2 +: 2] = 2'(PDM_PS_UP);
                        end
                    end
                    default: st_nxt.pst[p*2 +: 2] = 2'(PDM_PS_WAIT);
                endcase
                // Compare identifiers unless policy is none.
                st_nxt.mism[p] = (pdm_policy_t'(policy[p*2 +: 2]) != PDM_VAL_NONE)
                    && pdm_port_state_t'(st_r.pst[p*2 +: 2]) == PDM_PS_UP
                    && (cfg_device_id[p*16 +: 16] != seen_device_id[p*16 +: 16]
                    || cfg_vendor_id[p*16 +: 16] != seen_vendor_id[p*16 +: 16]);
                if (port_mandatory[p] && (pdm_port_state_t'(st_r.pst[p*2 +: 2]) != PDM_PS_UP
                    || st_r.mism[p]))
                begin
                    miss = 1'b1;
                end
            end
            else
            begin
                st_nxt.pst[p*2 +: 2] = 2'(PDM_PS_WAIT);
                st_nxt.wait_us[p*32 +: 32] = 32'h0;
                st_nxt.mism[p] = 1'b0;
            end
            if (!st_r.started[p])
            begin
                st_nxt.sw_o[p] = sw_init_high[p];
                st_nxt.aux_o[p] = aux_init_high[p];
                st_nxt.started[p] = 1'b1;
            end
            else if (tif.cycle_tick && !st_r.safe)
            begin
                st_nxt.sw_o[p] = outbound_image[p];
                st_nxt.aux_o[p] = outbound_image[p+NUM_PORTS];
            end
        end
        img[DIO_BYTE_POS*8 +: 8] = dio;
        st_nxt.len_err = (sum_in != (LEN_W+3)'(agg_in_len))
            || (sum_out != (LEN_W+3)'(agg_out_len));
        st_nxt.safe = miss;
        // Optional ports keep the exchange going.
        if (tif.cycle_tick && !st_r.safe)
        begin
            st_nxt.in_img = img;
            st_nxt.out_img = oimg;
        end
        else if (st_r.safe)
        begin
            st_nxt.in_img = '0;
            st_nxt.out_img = '0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            switching_pin_oe[p] = pdm_sw_mode_t'(switching_pin_mode[p*2 +: 2]) == PDM_SW_DOUT;
            auxiliary_pin_oe[p] = (p >= CLASS_A_FIRST) && auxiliary_pin_en[p];
            port_failed[p] = pdm_port_state_t'(st_r.pst[p*2 +: 2]) == PDM_PS_FAIL;
        end
    end

    assign switching_pin_out = st_r.sw_o;
    assign auxiliary_pin_out = st_r.aux_o;
    assign inbound_image = st_r.in_img;
    assign port_outbound = st_r.out_img;
    assign id_mismatch = st_r.mism;
    assign length_error = st_r.len_err;
    assign safe_mode = st_r.safe;
    assign cycle_strobe = tif.cycle_tick;
endmodule : pdm_port_mapper

// File: tb/pdm_wired_model.sv
/*
 Wired side model: four devices giving process data, identity and an
 operational flag. Assumes the bench chooses which devices are attached.
*/
`timescale 1ns/1ps
module pdm_wired_model
    import pdm_pkg::*;
(
    input wire logic clk,
    input wire logic [3:0] online,
    input wire logic [3:0] bad_id,
    output logic [1023:0] port_inbound,
    output logic [3:0] port_operational,
    output logic [63:0] seen_device_id,
    output logic [63:0] seen_vendor_id
);
    logic [23:0] hist_r = 24'h0;
    logic [7:0] junk_r = 8'h00;

    // A device reports operational only some cycles after it is attached.
    always_ff @(posedge clk)
    begin
        hist_r <= {hist_r[19:0], online};
        junk_r <= junk_r + 8'h35;
    end
    assign port_operational = hist_r[23:20] & online;

    // A detached device leaves its data lines changing every cycle.
    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            seen_device_id[p*16 +: 16] = 16'h1000 + 16'(p) + 16'(bad_id[p]);
            seen_vendor_id[p*16 +: 16] = 16'h2000 + 16'(p);
            for (int i = 0; i < IMG_BYTES; i++)
                port_inbound[(p*IMG_BYTES+i)*8 +: 8] = online[p] ? 8'(p*64+i+1) : junk_r;
        end
    end
endmodule : pdm_wired_model

// File: tb/pdm_port_mapper_asserts.sv
/*
 Checker bound to the port mapper top.
 Assumes mode and mandatory settings change only during reset.
*/
`timescale 1ns/1ps
module pdm_port_mapper_asserts
    import pdm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] switching_pin_mode,
    input wire logic [7:0] policy,
    input wire logic [23:0] in_len,
    input wire logic [23:0] out_len,
    input wire logic [5:0] agg_in_len,
    input wire logic [5:0] agg_out_len,
    input wire logic [15:0] cycle_time_us,
    input wire logic [3:0] port_mandatory,
    input wire logic [255:0] inbound_image,
    input wire logic [1023:0] port_outbound,
    input wire logic [3:0] switching_pin_oe,
    input wire logic [3:0] auxiliary_pin_oe,
    input wire logic [3:0] port_failed,
    input wire logic [3:0] id_mismatch,
    input wire logic cycle_strobe,
    input wire logic length_error,
    input wire logic safe_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic [3:0] link;
    logic [3:0] dout;
    logic [3:0] none;
    logic [7:0] sum_in;
    logic [7:0] sum_out;
    logic len_bad;
    logic [23:0] gap_r;
    logic seen_r;

    always_comb
    begin
        sum_in = 8'h01;
        sum_out = 8'h01;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            link[p] = switching_pin_mode[2*p +: 2] == PDM_SW_LINK;
            dout[p] = switching_pin_mode[2*p +: 2] == PDM_SW_DOUT;
            none[p] = policy[2*p +: 2] == PDM_VAL_NONE;
            sum_in += link[p] ? 8'(in_len[6*p +: 6]) : 8'h00;
            sum_out += link[p] ? 8'(out_len[6*p +: 6]) : 8'h00;
        end
        len_bad = sum_in != 8'(agg_in_len) || sum_out != 8'(agg_out_len);
    end

    // Cycles since the last link cycle strobe.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            gap_r <= 24'h0;
            seen_r <= 1'b0;
        end
        else
        begin
            gap_r <= cycle_strobe ? 24'h1 : gap_r + 24'h1;
            seen_r <= seen_r | cycle_strobe;
        end
    end

    sequence s_safe2;
        safe_mode ##1 safe_mode;
    endsequence
    property p_period;
        cycle_strobe && seen_r |-> gap_r == 24'(cycle_time_us) * 24'(CLK_MHZ);
    endproperty
    property p_pulse;
        cycle_strobe |=> !cycle_strobe;
    endproperty
    property p_blank;
        s_safe2 |-> inbound_image == '0 && port_outbound == '0;
    endproperty
    property p_sw_oe;
        switching_pin_oe == dout;
    endproperty
    property p_aux;
        auxiliary_pin_oe[1:0] == 2'h0;
    endproperty
    property p_len;
        1'b1 |=> length_error == $past(len_bad);
    endproperty
    property p_nofail;
        (port_failed & ~link) == 4'h0;
    endproperty
    property p_noid;
        (id_mismatch & none) == 4'h0;
    endproperty
    property p_opt;
        (port_mandatory & link) == 4'h0 |-> !safe_mode;
    endproperty
    property p_fail_safe;
        (port_failed & port_mandatory) != 4'h0 |=> safe_mode;
    endproperty

    a_period: assert property (p_period) else $error("cycle spacing");
    a_pulse: assert property (p_pulse) else $error("strobe width");
    a_blank: assert property (p_blank) else $error("image in safe");
    a_sw_oe: assert property (p_sw_oe) else $error("pin enable");
    a_aux: assert property (p_aux) else $error("aux enable");
    a_len: assert property (p_len) else $error("length flag");
    a_nofail: assert property (p_nofail) else $error("idle port fail");
    a_noid: assert property (p_noid) else $error("id check");
    a_opt: assert property (p_opt) else $error("optional safe");
    a_fail_safe: assert property (p_fail_safe) else $error("no safe");
endmodule : pdm_port_mapper_asserts

bind pdm_port_mapper pdm_port_mapper_asserts u_chk (.clk, .reset, .switching_pin_mode,
    .policy, .in_len, .out_len, .agg_in_len, .agg_out_len, .cycle_time_us, .port_mandatory,
    .inbound_image, .port_outbound, .switching_pin_oe, .auxiliary_pin_oe, .port_failed,
    .id_mismatch, .cycle_strobe, .length_error, .safe_mode);

// File: tb/tb_process_data_port_mapper.sv
/*
 Bench for the port mapper with the wired model on its far side.
 Assumes a 40 MHz clock; configuration changes at reset.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_process_data_port_mapper;
    import pdm_pkg::*;
    int failures = 0;
    int checks_done = 0;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] switching_pin_mode = 8'h90;
    logic [7:0] policy = 8'h01;
    logic [3:0] auxiliary_pin_en = 4'hc;
    logic [23:0] in_len = 24'h0000c2, out_len = 24'h000083;
    logic [19:0] in_ofs = 20'h00040, out_ofs = 20'h00002;
    logic [5:0] agg_in_len = 6'h06, agg_out_len = 6'h06;
    logic [3:0] sw_init_high = 4'h4, aux_init_high = 4'h8, port_mandatory = 4'h1;
    logic [15:0] cycle_time_us = 16'h0002;
    logic [31:0] timeout_us = 32'h00000014;
    logic [63:0] cfg_device_id = 64'h1003100210011000, cfg_vendor_id = 64'h2003200220012000;
    logic [3:0] switching_pin_in = 4'h8, auxiliary_pin_in = 4'h8, online = 4'h3, bad_id = 4'h0;
    logic [255:0] outbound_image = 256'h0, inbound_image;
    logic [1023:0] port_inbound, port_outbound;
    logic [63:0] seen_device_id, seen_vendor_id;
    logic [3:0] port_operational, switching_pin_out, switching_pin_oe, auxiliary_pin_out;
    logic [3:0] auxiliary_pin_oe, port_failed, id_mismatch;
    logic cycle_strobe, length_error, safe_mode;

    pdm_port_mapper DUT (.clk, .reset, .switching_pin_mode, .auxiliary_pin_en, .in_len, .in_ofs,
        .out_len, .out_ofs, .agg_in_len, .agg_out_len, .sw_init_high, .aux_init_high,
        .cycle_time_us, .timeout_us, .policy, .cfg_device_id, .cfg_vendor_id, .seen_device_id,
        .seen_vendor_id, .port_mandatory, .port_operational, .switching_pin_in,
        .auxiliary_pin_in, .port_inbound, .outbound_image, .inbound_image, .port_outbound,
        .switching_pin_out, .switching_pin_oe, .auxiliary_pin_out, .auxiliary_pin_oe,
        .port_failed, .id_mismatch, .cycle_strobe, .length_error, .safe_mode);
    pdm_wired_model wired (.clk, .online, .bad_id, .port_inbound, .port_operational,
        .seen_device_id, .seen_vendor_id);

    always #12.5 clk = ~clk;

    task automatic restart(input logic [3:0] on, input logic [3:0] man, input logic [7:0] pol,
        input logic [3:0] bad);
        @(posedge clk);
        reset <= 1'b1;
        online <= on;
        port_mandatory <= man;
        policy <= pol;
        bad_id <= bad;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
    endtask : restart

    // Waits for n link cycles, then lets the registered images settle.
    task automatic settle(input int n);
        repeat (n)
        begin
            @(posedge clk);
            while (cycle_strobe !== 1'b1)
                @(posedge clk);
        end
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic summarize;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    initial
    begin
        #200000;
        failures++;
        summarize();
    end

    initial
    begin
        for (int i = 1; i < 32; i++)
            outbound_image[i*8 +: 8] <= 8'ha0 + 8'(i);
        restart(4'h3, 4'h1, 8'h01, 4'h0);
        `CHK(switching_pin_out[2], 1'b1)
        `CHK(switching_pin_oe, 4'h4)
        `CHK(auxiliary_pin_out, 4'h8)
        `CHK(auxiliary_pin_oe, 4'hc)
        settle(2);
        for (int i = 0; i < 7; i++)
            `CHK(inbound_image[i*8 +: 8], i == 0 ? 8'h88 : i < 3 ? 8'(i) : i < 6 ? 8'(62 + i) : 8'h00)
        for (int i = 0; i < 4; i++)
        begin
            `CHK(port_outbound[i*8 +: 8], i < 3 ? 8'ha3 + 8'(i) : 8'h00)
            `CHK(port_outbound[256+i*8 +: 8], i < 2 ? 8'ha1 + 8'(i) : 8'h00)
        end
        `CHK(port_outbound[512 +: 8], 8'h00)
        `CHK({switching_pin_out[2], safe_mode, length_error, id_mismatch}, 7'h00)
        @(posedge clk);
        agg_in_len <= 6'h07;
        outbound_image[7:0] <= 8'h44;
        settle(1);
        `CHK({length_error, switching_pin_out[2]}, 2'h3)
        `CHK(auxiliary_pin_out, 4'h4)
        @(posedge clk);
        agg_in_len <= 6'h06;
        for (int p = 0; p < 4; p++)
        begin
            restart(4'h3, 4'h1, 8'(p), 4'h1);
            settle(2);
            `CHK({id_mismatch[0], safe_mode}, {2{p != 0}})
            `CHK(inbound_image[15:8], p != 0 ? 8'h00 : 8'h01)
        end
        restart(4'h1, 4'h4, 8'h01, 4'h0);
        repeat (600) @(posedge clk);
        #1;
        `CHK(port_failed, 4'h0)
        repeat (400) @(posedge clk);
        #1;
        `CHK({port_failed, safe_mode}, 5'h04)
        settle(1);
        `CHK(inbound_image[15:8], 8'h01)
        @(posedge clk);
        switching_pin_mode <= 8'hd0;
        restart(4'h2, 4'h1, 8'h01, 4'h0);
        repeat (1000) @(posedge clk);
        settle(1);
        `CHK({port_failed[0], safe_mode, length_error}, 3'h6)
        `CHK(inbound_image, 256'h0)
        summarize();
    end
endmodule : tb_process_data_port_mapper
